// [hdl/pcie_dma_app.sv]
// Purpose: Endpoint application layer: target memory, control registers, DMA channel.
// Assumes: Core strobes are on core_clk; rx header fields hold for a whole packet.
// Notes: Slave traffic has priority over the next DMA request at packet bounds.
module pcie_dma_app #(
  parameter int MAW = 13
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic srst,
  // Configuration from the core
  input wire logic [2:0] cfg_max_payload,
  input wire logic [2:0] cfg_max_read,
  input wire logic [7:0] vc1_tc_map,
  // Received requests
  input wire logic rx_valid,
  output logic rx_ready,
  input wire logic rx_write,
  input wire logic rx_last,
  input wire logic [5:0] rx_bar_hit,
  input wire logic [31:0] rx_addr,
  input wire logic [dma_app_pkg::LEN_W-1:0] rx_len_dw,
  input wire logic [7:0] rx_tag,
  input wire logic [15:0] rx_req_id,
  input wire logic [2:0] rx_tc,
  input wire logic [31:0] rx_data,
  // Received completion data for DMA reads
  input wire logic cpl_valid,
  input wire logic [31:0] cpl_data,
  // Transmit packets
  output logic tx_valid,
  input wire logic tx_ready,
  output dma_app_pkg::tx_kind_t tx_kind,
  output logic tx_sop,
  output logic tx_last,
  output logic [63:0] tx_addr,
  output logic [dma_app_pkg::LEN_W-1:0] tx_len_dw,
  output logic [7:0] tx_tag,
  output logic [15:0] tx_req_id,
  output logic [2:0] tx_tc,
  output logic tx_vc,
  output logic tx_td,
  output logic tx_ep,
  output logic [31:0] tx_data,
  // Status
  output logic dma_busy
);
  import dma_app_pkg::*;

  typedef enum logic [2:0] {ST_IDLE, ST_SLV_WR, ST_FETCH, ST_LOAD, ST_SEND} st_t;

  // ==========================================================
  // Elaboration check
  if (MAW < 6 || MAW > 20) begin : g_chk
    $error("pcie_dma_app: MAW out of range");
  end

  st_t st;
  logic [TGT_AW-1:0] s_ptr;
  logic s_ctrl;
  logic from_dma;
  logic [LEN_W-1:0] cnt;
  logic [31:0] dma_link_address_low;
  logic [31:0] dma_link_address_high;
  logic [31:0] dma_transfer_length;
  logic [CTRL_W-1:0] ctrl;
  logic [2:0] dma_traffic_class;
  logic [31:0] dma_local_memory_address;
  logic [63:0] cur_addr;
  logic [29:0] rem_dw;
  logic [30:0] out_dw;
  logic [MAW-1:0] m_ptr;
  logic [MAW-1:0] cpl_ptr;
  logic [31:0] pat_idx;
  logic [7:0] dma_tag;
  logic rx_acc, hit_ctrl, hit_tgt, reg_wr, start, dma_wr, issue, tx_fire, cpl_wr;
  logic [TGT_AW-1:0] wptr;
  logic [7:0] wr_off;
  logic [LEN_W-1:0] cap, chunk;
  logic [31:0] dma_data;

  ram_if #(.AW(TGT_AW)) tgt ();
  ram_if #(.AW(MAW)) mst ();

  word_ram #(.AW(TGT_AW)) u_target (.core_clk(core_clk), .port(tgt.mem));
  word_ram #(.AW(MAW)) u_master (.core_clk(core_clk), .port(mst.mem));

  // Request size in dwords from the smaller of two size codes
  function automatic logic [LEN_W-1:0] cap_dw(input logic [2:0] a, input logic [2:0] b);
    logic [2:0] c;
    c = (a < b) ? a : b;
    if (c > MAX_SIZE_CODE) begin
      c = MAX_SIZE_CODE;
    end
    return MIN_REQ_DW << c;
  endfunction : cap_dw

  // Control register read mux, unmapped offsets read zero
  function automatic logic [31:0] reg_rd(input logic [7:0] off);
    logic [31:0] v;
    v = 32'h0000_0000;
    unique case (off)
      OFF_LINK_LO: v = dma_link_address_low;
      OFF_LINK_HI: v = dma_link_address_high;
      OFF_LENGTH: v = dma_transfer_length;
      OFF_CONTROL: v = {dma_busy, 8'h00, ctrl};
      OFF_TCLASS: v = {29'h0, dma_traffic_class};
      OFF_LOCAL: v = dma_local_memory_address;
      default: v = 32'h0000_0000;
    endcase
    return v;
  endfunction : reg_rd

  // ==========================================================
  // Slave decode
  assign rx_ready = (st == ST_IDLE) || (st == ST_SLV_WR);
  assign rx_acc = rx_valid && rx_ready;
  assign hit_ctrl = |(rx_bar_hit & BAR_CONTROL);
  assign hit_tgt = |(rx_bar_hit & BAR_TARGET);
  assign wptr = (st == ST_IDLE) ? rx_addr[TGT_AW+1:2] : s_ptr;
  assign wr_off = {wptr[5:0], 2'b00};
  assign reg_wr = rx_acc && rx_write && hit_ctrl;
  assign start = reg_wr && (wr_off == OFF_CONTROL) && !dma_busy;

  // DMA request sizing and launch
  assign dma_wr = ctrl[DIR_BIT];
  assign cap = cap_dw(ctrl[SIZE_LSB+2:SIZE_LSB], dma_wr ? cfg_max_payload : cfg_max_read);
  assign chunk = (rem_dw < 30'(cap)) ? rem_dw[LEN_W-1:0] : cap;
  assign issue = (st == ST_IDLE) && !rx_valid && dma_busy && (rem_dw != 30'h0);
  assign tx_valid = (st == ST_SEND);
  assign tx_fire = tx_valid && tx_ready;
  assign tx_vc = vc1_tc_map[tx_tc];
  assign cpl_wr = cpl_valid && dma_busy && !dma_wr;

  // Memory ports
  assign tgt.addr = wptr;
  assign tgt.we = rx_acc && rx_write && hit_tgt;
  assign tgt.wdata = rx_data;
  assign mst.addr = dma_wr ? m_ptr : cpl_ptr;
  assign mst.we = cpl_wr;
  assign mst.wdata = cpl_data;

  // Write data source: pattern or master memory
  always_comb begin
    if (ctrl[PAT_DWORD_BIT]) begin
      dma_data = pat_idx;
    end else if (ctrl[PAT_BYTE_BIT]) begin
      dma_data = {pat_idx[5:0], 2'b11, pat_idx[5:0], 2'b10, pat_idx[5:0], 2'b01,
                  pat_idx[5:0], 2'b00};
    end else if (ctrl[PAT_ZERO_BIT]) begin
      dma_data = 32'h0000_0000;
    end else begin
      dma_data = mst.rdata;
    end
  end

  // ==========================================================
  // Sequencer
  always_ff @(posedge core_clk) begin
    if (srst) begin
      st <= ST_IDLE;
    end else begin
      unique case (st)
        ST_IDLE: begin
          if (rx_acc) begin
            st <= rx_write ? (rx_last ? ST_IDLE : ST_SLV_WR) : ST_FETCH;
          end else if (issue) begin
            st <= dma_wr ? ST_FETCH : ST_SEND;
          end
        end
        ST_SLV_WR: begin
          if (rx_acc && rx_last) begin
            st <= ST_IDLE;
          end
        end
        ST_FETCH: st <= ST_LOAD;
        ST_LOAD: st <= ST_SEND;
        ST_SEND: begin
          if (tx_fire) begin
            st <= tx_last ? ST_IDLE : ST_FETCH;
          end
        end
      endcase
    end
  end

  // Slave pointer and beat count
  always_ff @(posedge core_clk) begin
    if (srst) begin
      s_ptr <= '0;
      s_ctrl <= 1'b0;
      from_dma <= 1'b0;
      cnt <= '0;
    end else if (st == ST_IDLE && rx_acc) begin
      s_ptr <= rx_write ? wptr + 1'b1 : wptr;
      s_ctrl <= hit_ctrl;
      from_dma <= 1'b0;
      cnt <= (rx_len_dw == '0) ? LEN_W'(1) : rx_len_dw;
    end else if (issue) begin
      from_dma <= 1'b1;
      cnt <= chunk;
    end else if ((st == ST_SLV_WR && rx_acc) || tx_fire) begin
      s_ptr <= s_ptr + 1'b1;
      cnt <= cnt - 1'b1;
    end
  end

  // Transmit header and data
  always_ff @(posedge core_clk) begin
    if (srst) begin
      tx_kind <= TX_CPL;
      tx_sop <= 1'b0;
      tx_last <= 1'b0;
      tx_addr <= '0;
      tx_len_dw <= '0;
      tx_tag <= '0;
      tx_req_id <= '0;
      tx_tc <= '0;
      tx_td <= 1'b0;
      tx_ep <= 1'b0;
      tx_data <= '0;
    end else if (st == ST_IDLE && rx_acc && !rx_write) begin
      tx_kind <= TX_CPL;
      tx_sop <= 1'b1;
      tx_addr <= {32'h0, rx_addr};
      tx_len_dw <= (rx_len_dw == '0) ? LEN_W'(1) : rx_len_dw;
      tx_tag <= rx_tag;
      tx_req_id <= rx_req_id;
      tx_tc <= rx_tc;
      tx_td <= 1'b0;
      tx_ep <= 1'b0;
    end else if (issue) begin
      tx_kind <= dma_wr ? TX_MWR : TX_MRD;
      tx_sop <= 1'b1;
      tx_last <= !dma_wr;
      tx_data <= '0;
      tx_addr <= cur_addr;
      tx_len_dw <= chunk;
      tx_tag <= dma_tag;
      tx_req_id <= '0;
      tx_tc <= dma_traffic_class;
      tx_td <= ctrl[TD_BIT];
      tx_ep <= ctrl[EP_BIT];
    end else if (st == ST_LOAD) begin
      tx_last <= (cnt == LEN_W'(1));
      tx_data <= from_dma ? dma_data : (s_ctrl ? reg_rd({s_ptr[5:0], 2'b00}) : tgt.rdata);
    end else if (tx_fire) begin
      tx_sop <= 1'b0;
    end
  end

  // ==========================================================
  // Control registers
  always_ff @(posedge core_clk) begin
    if (srst) begin
      dma_link_address_low <= REG_RESET;
      dma_link_address_high <= REG_RESET;
      dma_transfer_length <= REG_RESET;
      ctrl <= REG_RESET[CTRL_W-1:0];
      dma_traffic_class <= TCLASS_RESET;
      dma_local_memory_address <= REG_RESET;
    end else if (reg_wr) begin
      unique case (wr_off)
        OFF_LINK_LO: dma_link_address_low <= rx_data;
        OFF_LINK_HI: dma_link_address_high <= rx_data;
        OFF_LENGTH: dma_transfer_length <= rx_data;
        OFF_CONTROL: begin
          if (!dma_busy) begin
            ctrl <= rx_data[CTRL_W-1:0] & CTRL_WMASK;
          end
        end
        OFF_TCLASS: dma_traffic_class <= rx_data[2:0];
        OFF_LOCAL: dma_local_memory_address <= rx_data;
        default: ;
      endcase
    end
  end

  // DMA engine state
  always_ff @(posedge core_clk) begin
    if (srst) begin
      dma_busy <= 1'b0;
      cur_addr <= '0;
      rem_dw <= '0;
      out_dw <= '0;
      m_ptr <= '0;
      cpl_ptr <= '0;
      pat_idx <= '0;
      dma_tag <= '0;
    end else if (start) begin
      dma_busy <= 1'b1;
      cur_addr <= {dma_link_address_high, dma_link_address_low};
      rem_dw <= dma_transfer_length[31:2];
      out_dw <= '0;
      m_ptr <= dma_local_memory_address[MAW+1:2];
      cpl_ptr <= dma_local_memory_address[MAW+1:2];
      pat_idx <= '0;
    end else begin
      if (issue) begin
        cur_addr <= cur_addr + {51'h0, chunk, 2'b00};
        rem_dw <= rem_dw - 30'(chunk);
        dma_tag <= dma_tag + 1'b1;
      end
      out_dw <= out_dw + ((issue && !dma_wr) ? 31'(chunk) : 31'h0) - (cpl_wr ? 31'h1 : 31'h0);
      if (tx_fire && from_dma && dma_wr) begin
        m_ptr <= m_ptr + 1'b1;
        pat_idx <= pat_idx + 1'b1;
      end
      if (cpl_wr) begin
        cpl_ptr <= cpl_ptr + 1'b1;
      end
      if (dma_busy && rem_dw == 30'h0 && out_dw == 31'h0 && st == ST_IDLE) begin
        dma_busy <= 1'b0;
      end
    end
  end

  // ==========================================================
  // Assertions
  property p_start_loads;
    @(posedge core_clk) disable iff (srst)
    start |=> dma_busy && cur_addr == {$past(dma_link_address_high), $past(dma_link_address_low)};
  endproperty
  a_start_loads: assert property (p_start_loads) else $error("start did not load");

  property p_busy_clear;
    @(posedge core_clk) disable iff (srst)
    $fell(dma_busy) |-> $past(rem_dw) == 30'h0 && $past(out_dw) == 31'h0;
  endproperty
  a_busy_clear: assert property (p_busy_clear) else $error("busy cleared early");

  property p_len_write;
    @(posedge core_clk) disable iff (srst)
    reg_wr && wr_off == OFF_LENGTH |=> dma_transfer_length == $past(rx_data);
  endproperty
  a_len_write: assert property (p_len_write) else $error("length write lost");

  property p_read_cpl;
    @(posedge core_clk) disable iff (srst)
    rx_acc && !rx_write |-> ##3 tx_valid && tx_kind == TX_CPL && tx_sop && tx_tag == $past(rx_tag, 3);
  endproperty
  a_read_cpl: assert property (p_read_cpl) else $error("no completion");

  property p_req_vc;
    @(posedge core_clk) disable iff (srst)
    tx_valid && tx_kind != TX_CPL |-> tx_tc == dma_traffic_class && tx_vc == vc1_tc_map[dma_traffic_class];
  endproperty
  a_req_vc: assert property (p_req_vc) else $error("wrong channel");

  property p_req_size;
    @(posedge core_clk) disable iff (srst)
    tx_valid && tx_sop && tx_kind != TX_CPL |-> tx_len_dw != '0 && tx_len_dw <= cap;
  endproperty
  a_req_size: assert property (p_req_size) else $error("request too large");

  property p_req_flags;
    @(posedge core_clk) disable iff (srst)
    tx_valid && tx_kind != TX_CPL |-> tx_td == ctrl[TD_BIT] && tx_ep == ctrl[EP_BIT];
  endproperty
  a_req_flags: assert property (p_req_flags) else $error("header flags wrong");

  property p_zero_data;
    @(posedge core_clk) disable iff (srst)
    tx_valid && tx_kind == TX_MWR && ctrl[PAT_ZERO_BIT] && !ctrl[PAT_DWORD_BIT] && !ctrl[PAT_BYTE_BIT]
      |-> tx_data == 32'h0000_0000;
  endproperty
  a_zero_data: assert property (p_zero_data) else $error("zero pattern wrong");

endmodule : pcie_dma_app

// [common/dma_app_pkg.sv]
// Purpose: Shared constants and types for the endpoint DMA application layer.
// Assumes: 32-bit data, dword-aligned accesses, one clock (core_clk).
// Notes: Register offsets are byte offsets within the control register window.
package dma_app_pkg;

  // ==========================================================
  // Register offsets
  localparam logic [7:0] OFF_LINK_LO = 8'h00;
  localparam logic [7:0] OFF_LINK_HI = 8'h04;
  localparam logic [7:0] OFF_LENGTH = 8'h08;
  localparam logic [7:0] OFF_CONTROL = 8'h0c;
  localparam logic [7:0] OFF_TCLASS = 8'h10;
  localparam logic [7:0] OFF_LOCAL = 8'h14;

  // ==========================================================
  // Control register fields
  localparam int BUSY_BIT = 31;
  localparam int PAT_DWORD_BIT = 22;
  localparam int PAT_BYTE_BIT = 21;
  localparam int PAT_ZERO_BIT = 20;
  localparam int SIZE_LSB = 16;
  localparam int TD_BIT = 15;
  localparam int EP_BIT = 14;
  localparam int DIR_BIT = 0;
  localparam int CTRL_W = 23;
  localparam logic [CTRL_W-1:0] CTRL_WMASK = 23'h77c001;
  localparam logic [31:0] REG_RESET = 32'h0000_0000;
  localparam logic [2:0] TCLASS_RESET = 3'h0;

  // ==========================================================
  // Window decode and sizes
  localparam logic [5:0] BAR_TARGET = 6'h33;
  localparam logic [5:0] BAR_CONTROL = 6'h0c;
  localparam int TGT_AW = 13;
  localparam int LEN_W = 11;
  localparam logic [LEN_W-1:0] MIN_REQ_DW = 11'h020;
  localparam logic [2:0] MAX_SIZE_CODE = 3'h5;

  typedef enum logic [1:0] {TX_CPL, TX_MRD, TX_MWR} tx_kind_t;

endpackage : dma_app_pkg

// [common/ram_if.sv]
// Purpose: Single-port word memory connection.
// Assumes: Read data is valid one clock after the address.
// Notes: None.
interface ram_if #(parameter int AW = 13);
  logic [AW-1:0] addr;
  logic we;
  logic [31:0] wdata;
  logic [31:0] rdata;
  modport user (output addr, output we, output wdata, input rdata);
  modport mem (input addr, input we, input wdata, output rdata);
endinterface : ram_if

// [hdl/word_ram.sv]
// Purpose: Synchronous single-port word memory.
// Assumes: Write and read share one address; read-before-write.
// Notes: Contents are not reset.
module word_ram #(
  parameter int AW = 13
) (
  // Clock
  input wire logic core_clk,
  // Memory port
  ram_if.mem port
);

  logic [31:0] mem [2**AW];

  // ==========================================================
  // Elaboration check
  if (AW < 2 || AW > 20) begin : g_chk
    $error("word_ram: AW out of range");
  end

  // Write and registered read
  always_ff @(posedge core_clk) begin
    if (port.we) begin
      mem[port.addr] <= port.wdata;
    end
    port.rdata <= mem[port.addr];
  end

endmodule : word_ram

// [testbench/link_partner.sv]
// Purpose: Core and host stand-in: drains tx beats, answers DMA reads with data.
// Assumes: Beats fire at core_clk rise with tx_valid and tx_ready high.
// Notes: Completion data is logged in sent for the bench.
module link_partner (
  // Clock and reset
  input wire logic core_clk,
  input wire logic srst,
  // Transmit side of the design
  input wire logic tx_valid,
  output logic tx_ready,
  input wire dma_app_pkg::tx_kind_t tx_kind,
  input wire logic [dma_app_pkg::LEN_W-1:0] tx_len_dw,
  // Completion data back to the design
  output logic cpl_valid,
  output logic [31:0] cpl_data
);
  timeunit 1ns;
  timeprecision 1ns;
  import dma_app_pkg::*;
  int unsigned asked;
  int unsigned given;
  int unsigned owed;
  logic [31:0] sent[$];
  logic [31:0] d;
  // ==========================================================
  // Dwords still owed to the design
  assign owed = asked - given;
  // Dwords asked for by every read request that fires
  always @(posedge core_clk) begin
    if (srst)
      asked = 0;
    else if (tx_valid && tx_ready && tx_kind == TX_MRD)
      asked = asked + tx_len_dw;
  end
  // Idle values in reset; random stalls, gapped completion dwords, scrambled data
  always @(negedge core_clk) begin
    d = $urandom;
    if (srst) begin
      tx_ready <= 1'b0;
      cpl_valid <= 1'b0;
      cpl_data <= 32'h0;
      given = 0;
    end else begin
      tx_ready <= d[3:2] != 2'h0;
      if (owed != 0 && d[1:0] == 2'h0) begin
        d = $urandom;
        cpl_valid <= 1'b1;
        cpl_data <= d;
        sent.push_back(d);
        given = given + 1;
      end else begin
        cpl_valid <= 1'b0;
        cpl_data <= ~cpl_data;
      end
    end
  end
endmodule : link_partner

// [testbench/pcie_endpoint_simple_dma_app_tb.sv]
// Purpose: Self-checking bench for the endpoint DMA application layer.
// Assumes: Inputs change at core_clk fall; single-dword slave packets except one three-dword corner.
// Notes: Random traffic from a fixed seed with hand-picked corners.
module pcie_endpoint_simple_dma_app_tb;
  timeunit 1ns;
  timeprecision 1ns;
  import dma_app_pkg::*;
  typedef struct {
    tx_kind_t kind;
    logic sop, last, vc, td, ep;
    logic [63:0] addr;
    logic [LEN_W-1:0] len;
    logic [31:0] data;
    logic [7:0] tag;
    logic [15:0] rid;
    logic [2:0] tc;
  } beat_t;
  localparam logic [7:0] OFFS [7] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h10, 8'h14, 8'h18};
  localparam logic [5:0] TGT [4] = '{6'h01, 6'h02, 6'h10, 6'h20};
  localparam int CODES [4] = '{0, 1, 3, 4};
  localparam int PATS [4] = '{22, 21, 20, 22};
  logic core_clk, srst, rx_valid, rx_ready, rx_write, rx_last, cpl_valid;
  logic [2:0] cfg_max_payload, cfg_max_read, rx_tc, tx_tc, tcr;
  logic [7:0] vc1_tc_map, rx_tag, tx_tag;
  logic [5:0] rx_bar_hit;
  logic [31:0] rx_addr, rx_data, cpl_data, tx_data, v, w, ctrl, loc;
  logic [LEN_W-1:0] rx_len_dw, tx_len_dw;
  logic [15:0] rx_req_id, tx_req_id;
  logic tx_valid, tx_ready, tx_sop, tx_last, tx_vc, tx_td, tx_ep, dma_busy;
  tx_kind_t tx_kind;
  logic [63:0] tx_addr, la;
  int n_errors, n_tests, cap, pbit;
  beat_t b, got;
  beat_t cpls[$], reqs[$];
  logic [31:0] sh[logic [12:0]];

  pcie_dma_app u_dut (.core_clk, .srst, .cfg_max_payload, .cfg_max_read, .vc1_tc_map,
    .rx_valid, .rx_ready, .rx_write, .rx_last, .rx_bar_hit, .rx_addr, .rx_len_dw, .rx_tag,
    .rx_req_id, .rx_tc, .rx_data, .cpl_valid, .cpl_data, .tx_valid, .tx_ready, .tx_kind,
    .tx_sop, .tx_last, .tx_addr, .tx_len_dw, .tx_tag, .tx_req_id, .tx_tc, .tx_vc, .tx_td,
    .tx_ep, .tx_data, .dma_busy);
  link_partner u_partner (.core_clk, .srst, .tx_valid, .tx_ready, .tx_kind, .tx_len_dw,
    .cpl_valid, .cpl_data);

  // ==========================================================
  // Clock
  initial begin
    core_clk = 1'b0;
    forever #50 core_clk = ~core_clk;
  end
  // Log beats that fire at the next rise; busy must cover owed read data
  always @(negedge core_clk) begin
    #1;
    b = '{tx_kind, tx_sop, tx_last, tx_vc, tx_td, tx_ep, tx_addr, tx_len_dw, tx_data, tx_tag,
      tx_req_id, tx_tc};
    if (tx_valid === 1'b1 && tx_ready === 1'b1 && srst === 1'b0) begin
      if (tx_kind == TX_CPL)
        cpls.push_back(b);
      else
        reqs.push_back(b);
    end
    if (u_partner.owed != 0)
      chk(dma_busy, 1);
  end

  // ==========================================================
  // Checking and closing
  task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_errors++;
      $display("BAD %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic summarize();
    $display("errors %0d comparisons %0d", n_errors, n_tests);
    if (n_errors == 0 && n_tests > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : summarize
  task automatic hang();
    n_errors++;
    summarize();
  endtask : hang
  function automatic logic [31:0] pat(input int p, input int n);
    logic [7:0] q;
    q = 8'(4 * n);
    case (p)
      PAT_DWORD_BIT: return n;
      PAT_BYTE_BIT: return {q + 8'h3, q + 8'h2, q + 8'h1, q};
      default: return 32'h0;
    endcase
  endfunction : pat

  // ==========================================================
  // Bus tasks
  task automatic await(input logic s);
    int k;
    k = 0;
    while (dma_busy !== s) begin
      @(negedge core_clk);
      k++;
      if (k > 20000) hang();
    end
  endtask : await
  task automatic send(input logic wr_n, input logic [5:0] bar, input logic [31:0] a,
      input logic [31:0] d);
    int k;
    k = 0;
    @(negedge core_clk);
    rx_valid = 1'b1;
    rx_write = wr_n;
    rx_bar_hit = bar;
    rx_addr = a;
    rx_data = d;
    rx_tag = 8'($urandom);
    rx_req_id = 16'($urandom);
    rx_tc = 3'($urandom);
    #1;
    while (rx_ready !== 1'b1) begin
      @(negedge core_clk);
      k++;
      if (k > 1000) hang();
    end
    @(negedge core_clk);
    rx_valid = 1'b0;
    rx_data = ~d;
  endtask : send
  task automatic rd(input logic [5:0] bar, input logic [31:0] a, input logic [31:0] exp);
    beat_t c;
    int k;
    k = 0;
    send(1'b0, bar, a, $urandom);
    while (cpls.size() == 0) begin
      @(negedge core_clk);
      k++;
      if (k > 1000) hang();
    end
    c = cpls.pop_front();
    chk(c.data, exp);
    chk({c.tag, c.rid, c.tc, c.last}, {rx_tag, rx_req_id, rx_tc, 1'b1});
  endtask : rd
  task automatic wr(input logic [7:0] off, input logic [31:0] d);
    send(1'b1, 6'h04 << ($urandom % 2), {24'h0, off}, d);
  endtask : wr
  task automatic dma(input logic [31:0] lenb, input logic [31:0] c);
    tcr = 3'($urandom);
    vc1_tc_map = 8'($urandom);
    wr(OFF_TCLASS, {29'h0, tcr});
    wr(OFF_LINK_LO, la[31:0]);
    wr(OFF_LINK_HI, la[63:32]);
    wr(OFF_LOCAL, loc);
    wr(OFF_LENGTH, lenb);
    wr(OFF_CONTROL, c);
    await(1'b1);
  endtask : dma
  task automatic expect_reqs(input tx_kind_t kd, input int dw, input int p);
    beat_t c;
    int i, n;
    i = 0;
    while (i < dw) begin
      n = (dw - i < cap) ? dw - i : cap;
      for (int j = 0; j < (kd == TX_MWR ? n : 1); j++) begin
        if (reqs.size() == 0) hang();
        c = reqs.pop_front();
        chk(c.kind, kd);
        chk({c.sop, c.last}, {j == 0, kd == TX_MRD || j == n - 1});
        if (j == 0) begin
          chk(c.addr, la + 4 * i);
          chk(c.len, n);
          chk({c.td, c.ep}, {ctrl[TD_BIT], ctrl[EP_BIT]});
          chk(c.vc, vc1_tc_map[tcr]);
        end
        if (kd == TX_MWR)
          chk(c.data, p != 0 ? pat(p, i + j) : u_partner.sent[i + j]);
      end
      i += n;
    end
    chk(reqs.size(), 0);
  endtask : expect_reqs

  // ==========================================================
  // Main sequence
  initial begin
    srst = 1'b1;
    {rx_valid, rx_write, rx_bar_hit, rx_addr, rx_data, rx_tag, rx_req_id, rx_tc} = '0;
    rx_last = 1'b1;
    rx_len_dw = LEN_W'(1);
    cfg_max_payload = 3'h5;
    cfg_max_read = 3'h5;
    vc1_tc_map = 8'h0;
    void'($urandom(32'h7ea3));
    repeat (20) @(negedge core_clk);
    srst = 1'b0;
    // Reset values, then readback; offset 0x18 is unmapped
    foreach (OFFS[i])
      rd(6'h04, {24'h0, OFFS[i]}, 32'h0);
    foreach (OFFS[i]) begin
      v = $urandom;
      if (OFFS[i] != OFF_CONTROL) begin
        wr(OFFS[i], v);
        rd(6'h08, {24'h0, OFFS[i]}, OFFS[i] == 8'h18 ? 32'h0 :
          OFFS[i] == OFF_TCLASS ? {29'h0, v[2:0]} : v);
      end
    end
    // Zero length: busy pulses once, attributes still stored
    wr(OFF_LENGTH, 32'h0);
    wr(OFF_CONTROL, v);
    await(1'b1);
    await(1'b0);
    rd(6'h04, {24'h0, OFF_CONTROL}, {9'h0, v[22:0] & CTRL_WMASK});
    // Target memory through every window, upper address bits scrambled
    for (int i = 0; i < 16; i++) begin
      v = $urandom;
      w = $urandom;
      sh[w[14:2]] = v;
      send(1'b1, TGT[$urandom % 4], w, v);
    end
    foreach (sh[k])
      rd(TGT[$urandom % 4], {17'($urandom), k, 2'b00}, sh[k]);
    // Three write beats in one packet, read back as one three-dword packet
    w = $urandom;
    rx_len_dw = LEN_W'(3);
    for (int i = 0; i < 3; i++) begin
      rx_last = (i == 2);
      send(1'b1, 6'h10, 32'h0001_0100, w + 32'(i));
    end
    send(1'b0, 6'h20, 32'h0003_0100, ~w);
    for (int i = 0; i < 200 && cpls.size() < 3; i++)
      @(negedge core_clk);
    if (cpls.size() != 3) hang();
    for (int i = 0; i < 3; i++) begin
      got = cpls.pop_front();
      chk({got.data, got.sop, got.last}, {w + 32'(i), i == 0, i == 2});
      chk(got.len, 3);
    end
    rx_len_dw = LEN_W'(1);
    // Writes from each pattern, four of the six size codes; ragged length bits
    for (int i = 0; i < 4; i++) begin
      cfg_max_payload = 3'($urandom % 6);
      cap = 32 << (CODES[i] < cfg_max_payload ? CODES[i] : cfg_max_payload);
      pbit = PATS[i];
      ctrl = (1 << pbit) | (CODES[i] << SIZE_LSB) | ($urandom & 32'hc000) | 1;
      la = {$urandom, $urandom & 32'hffff_fffc};
      loc = $urandom % 256 * 4;
      dma((cap + 1) * 4 + i, ctrl);
      if (i == 0) begin
        rd(6'h04, {24'h0, OFF_CONTROL}, {1'b1, 8'h0, ctrl[22:0] & CTRL_WMASK});
        wr(OFF_CONTROL, ~ctrl);
      end
      await(1'b0);
      expect_reqs(TX_MWR, cap + 1, pbit);
      rd(6'h08, {24'h0, OFF_CONTROL}, {9'h0, ctrl[22:0] & CTRL_WMASK});
    end
    // Read into master memory, then write it back out
    cfg_max_read = 3'($urandom % 6);
    cap = 32 << (cfg_max_read < 4 ? cfg_max_read : 4);
    ctrl = (4 << SIZE_LSB) | ($urandom & 32'hc000);
    la = {$urandom, $urandom & 32'hffff_fffc};
    loc = $urandom % 256 * 4;
    dma(32'd400, ctrl);
    await(1'b0);
    chk(u_partner.owed, 0);
    expect_reqs(TX_MRD, 100, 0);
    chk(u_partner.sent.size(), 100);
    cfg_max_payload = 3'h5;
    cap = 32;
    ctrl = 32'h1;
    dma(32'd400, ctrl);
    await(1'b0);
    expect_reqs(TX_MWR, 100, 0);
    summarize();
  end
endmodule : pcie_endpoint_simple_dma_app_tb
